// ### design/byte_sum.sv
// Running modulo-256 byte sum used for frame checksums
`timescale 1ns/1ps
module byte_sum
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic add,
    input wire logic [7:0] data,
    output logic [7:0] sum
);
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            sum <= 8'h00;
        // A byte that arrives with the clear opens the new sum, so it is not lost
        else if (clear)
            sum <= add ? data : 8'h00;
        else if (add)
            sum <= sum + data;
    end
endmodule

// ### design/core_shifter.sv
// Assembles the seven core bytes of a command, value most significant byte first
`timescale 1ns/1ps
module core_shifter
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [7:0] data,
    output cmd_frame_pkg::cmd_core_t core
);
    import cmd_frame_pkg::*;

    // Bytes shift in at the bottom, so the first value byte lands in value[31:24]
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            core <= '0;
        else if (load)
            core <= {core[47:0], data};
    end
endmodule

// ### design/motion_command_frame_interpreter.sv
// Command frame interpreter: receive, check, execute or store, reply
`timescale 1ns/1ps
module motion_command_frame_interpreter
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic can_mode,
    input wire logic [7:0] module_addr,
    input wire logic [7:0] reply_addr,
    input wire cmd_frame_pkg::byte_beat_t rx,
    input wire logic rx_frame_start,
    input wire logic store_mode,
    input wire logic store_ready,
    output cmd_frame_pkg::cmd_core_t store_cmd,
    output logic store_req,
    input wire logic store_done,
    input wire logic store_locked,
    output cmd_frame_pkg::cmd_core_t exec_cmd,
    output logic exec_req,
    input wire logic exec_done,
    input wire cmd_frame_pkg::exec_result_t exec_result,
    output cmd_frame_pkg::byte_beat_t tx,
    input wire logic tx_ready,
    output logic tx_last,
    output logic tx_busy
);
    import cmd_frame_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {IDLE, RECEIVE, DISPATCH, WAIT_EXEC, WAIT_STORE, SEND} phase_t;

    phase_t phase;
    logic [3:0] rx_count;
    logic [3:0] tx_count;
    logic addr_match;
    logic sum_clear;
    logic sum_add;
    logic [7:0] rx_sum;
    logic [7:0] tx_sum;
    logic core_load;
    cmd_core_t core;
    logic [7:0] reply_status;
    logic [31:0] reply_value;
    logic [7:0] reply_opcode;
    logic [7:0] next_tx_byte;
    logic [3:0] frame_len;
    logic [3:0] reply_len;
    logic frame_complete;
    logic tx_take;
    logic [3:0] tx_slot;

    assign frame_len = can_mode ? 4'(CORE_BYTES) : 4'(SERIAL_BYTES);
    // CAN reply drops both address bytes and the checksum: status, opcode, value
    assign reply_len = can_mode ? 4'(VALUE_BYTES + 2) : 4'(SERIAL_BYTES);
    assign tx_take = tx.valid && tx_ready;
    // Slot loaded next: the one after the byte being taken, or the first one
    assign tx_slot = tx_take ? tx_count + 4'h1 : tx_count;

    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------
    // Core bytes are positions 1..7 of a serial frame and 0..6 of a CAN frame
    assign core_load = rx.valid && (phase == RECEIVE || phase == IDLE)
                       && (can_mode ? (rx_count < 4'(CORE_BYTES))
                                    : (rx_count >= 4'h1 && rx_count <= 4'(CORE_BYTES)));
    assign sum_clear = rx_frame_start && phase == IDLE;
    assign sum_add = rx.valid && (phase == RECEIVE || phase == IDLE)
                     && rx_count < 4'(SERIAL_BYTES - 1);
    assign frame_complete = rx.valid && (phase == RECEIVE || phase == IDLE)
                            && rx_count == frame_len - 4'h1;

    byte_sum rx_sum_unit
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .clear(sum_clear),
        .add(sum_add),
        .data(rx.data),
        .sum(rx_sum)
    );

    core_shifter shifter
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .load(core_load),
        .data(rx.data),
        .core(core)
    );

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rx_count <= 4'h0;
        else if (rx_frame_start && phase == IDLE)
            rx_count <= rx.valid ? 4'h1 : 4'h0;
        else if (rx.valid && phase == RECEIVE)
            rx_count <= frame_complete ? 4'h0 : rx_count + 4'h1;
        else if (phase != RECEIVE)
            rx_count <= 4'h0;
    end

    // Address byte is the first serial byte; CAN filtering is done by the identifier
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            addr_match <= 1'b0;
        else if (rx.valid && rx_count == 4'h0 && (phase == IDLE || phase == RECEIVE))
            addr_match <= can_mode || rx.data == module_addr;
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Bytes arriving outside IDLE/RECEIVE are ignored; the master must wait anyway
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            phase <= IDLE;
        else
        begin
            unique case (phase)
                IDLE:
                    if (rx_frame_start)
                        phase <= RECEIVE;
                RECEIVE:
                    if (rx.valid && rx_count == frame_len - 4'h1)
                        phase <= DISPATCH;
                DISPATCH:
                    if (!can_mode && !addr_match)
                        phase <= IDLE;
                    else if (!can_mode && rx_sum != rx_last_byte)
                        phase <= SEND;
                    else if (store_mode)
                    begin
                        // Storage that is not ready keeps the command parked here
                        if (store_ready)
                            phase <= WAIT_STORE;
                    end
                    else
                        phase <= WAIT_EXEC;
                WAIT_EXEC:
                    if (exec_done)
                        phase <= SEND;
                WAIT_STORE:
                    if (store_done || store_locked)
                        phase <= SEND;
                SEND:
                    if (tx_take && tx_count == reply_len - 4'h1)
                        phase <= IDLE;
            endcase
        end
    end

    // The checksum byte is still on rx.data in DISPATCH only if the source holds it;
    // it is captured here to avoid depending on that.
    logic [7:0] rx_last_byte;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rx_last_byte <= 8'h00;
        else if (frame_complete)
            rx_last_byte <= rx.data;
    end

    // ------------------------------------------------------------
    // Execution and storage requests
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            exec_req <= 1'b0;
            exec_cmd <= '0;
        end
        else
        begin
            exec_req <= phase == DISPATCH && !store_mode && (can_mode
                        || (addr_match && rx_sum == rx_last_byte));
            if (phase == DISPATCH)
                exec_cmd <= core;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            store_req <= 1'b0;
            store_cmd <= '0;
        end
        else
        begin
            store_req <= phase == DISPATCH && store_mode && store_ready && (can_mode
                         || (addr_match && rx_sum == rx_last_byte));
            if (phase == DISPATCH)
                store_cmd <= core;
        end
    end

    // ------------------------------------------------------------
    // Reply contents
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            reply_status <= ST_OK;
            reply_value <= 32'h0000_0000;
            reply_opcode <= 8'h00;
        end
        else if (phase == DISPATCH)
        begin
            reply_opcode <= core.opcode;
            reply_value <= 32'h0000_0000;
            if (!can_mode && rx_sum != rx_last_byte)
                reply_status <= ST_BAD_SUM;
        end
        else if (phase == WAIT_EXEC && exec_done)
        begin
            reply_status <= exec_result.status;
            reply_value <= exec_result.value;
        end
        else if (phase == WAIT_STORE && (store_done || store_locked))
            reply_status <= store_locked ? ST_LOCKED : ST_STORED;
    end

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    always_comb
    begin
        next_tx_byte = 8'h00;
        if (can_mode)
        begin
            unique case (tx_slot)
                4'h0: next_tx_byte = reply_status;
                4'h1: next_tx_byte = reply_opcode;
                4'h2: next_tx_byte = reply_value[31:24];
                4'h3: next_tx_byte = reply_value[23:16];
                4'h4: next_tx_byte = reply_value[15:8];
                4'h5: next_tx_byte = reply_value[7:0];
                default: next_tx_byte = 8'h00;
            endcase
        end
        else
        begin
            unique case (tx_slot)
                4'h0: next_tx_byte = reply_addr;
                4'h1: next_tx_byte = module_addr;
                4'h2: next_tx_byte = reply_status;
                4'h3: next_tx_byte = reply_opcode;
                4'h4: next_tx_byte = reply_value[31:24];
                4'h5: next_tx_byte = reply_value[23:16];
                4'h6: next_tx_byte = reply_value[15:8];
                4'h7: next_tx_byte = reply_value[7:0];
                4'h8: next_tx_byte = tx_sum + tx.data;
                default: next_tx_byte = 8'h00;
            endcase
        end
    end

    // Sum holds bytes already gone; the byte leaving now is added at the checksum slot
    byte_sum tx_sum_unit
    (
        .ref_clk(ref_clk),
        .rst(rst),
        .clear(phase != SEND),
        .add(tx_take && tx_count < 4'(SERIAL_BYTES - 1)),
        .data(tx.data),
        .sum(tx_sum)
    );

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            tx_count <= 4'h0;
        else if (phase != SEND)
            tx_count <= 4'h0;
        else if (tx_take)
            tx_count <= tx_count + 4'h1;
    end

    // Bus is taken only in SEND, which is reached only through a received frame
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            tx <= '0;
            tx_last <= 1'b0;
            tx_busy <= 1'b0;
        end
        else
        begin
            tx_busy <= phase == SEND && !(tx_take && tx_count == reply_len - 4'h1);
            if (phase == SEND && !(tx_take && tx_count == reply_len - 4'h1))
            begin
                tx.valid <= 1'b1;
                if (!tx.valid || tx_take)
                begin
                    tx.data <= next_tx_byte;
                    tx_last <= tx_slot == reply_len - 4'h1;
                end
            end
            else
            begin
                tx.valid <= 1'b0;
                tx_last <= 1'b0;
            end
        end
    end
endmodule

// ### include/cmd_frame_pkg.sv
// Shared constants and carrier types of the motion command frame interpreter
package cmd_frame_pkg;

    // ------------------------------------------------------------
    // Frame geometry
    // ------------------------------------------------------------
    localparam int CORE_BYTES = 7;
    localparam int SERIAL_BYTES = 9;
    localparam int VALUE_BYTES = 4;

    // ------------------------------------------------------------
    // Status codes
    // ------------------------------------------------------------
    localparam logic [7:0] ST_OK = 8'h64;
    localparam logic [7:0] ST_STORED = 8'h65;
    localparam logic [7:0] ST_BAD_SUM = 8'h01;
    localparam logic [7:0] ST_BAD_OPCODE = 8'h02;
    localparam logic [7:0] ST_BAD_TYPE = 8'h03;
    localparam logic [7:0] ST_BAD_VALUE = 8'h04;
    localparam logic [7:0] ST_LOCKED = 8'h05;
    localparam logic [7:0] ST_UNAVAILABLE = 8'h06;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_MODULE_ADDR = 8'h01;
    localparam logic [7:0] RST_REPLY_ADDR = 8'h02;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] kind;
        logic [7:0] selector;
        logic [31:0] value;
    } cmd_core_t;

    typedef struct packed {
        logic [7:0] status;
        logic [31:0] value;
    } exec_result_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_beat_t;

endpackage

// ### sim/host_model.sv
// Host bus master model: sends command frames and collects reply bytes
`timescale 1ns/1ps
module host_model
(
    input wire logic ref_clk,
    input wire logic can_mode,
    input wire logic slow,
    output cmd_frame_pkg::byte_beat_t rx,
    output logic rx_frame_start,
    input wire cmd_frame_pkg::byte_beat_t tx,
    output logic tx_ready
);
    import cmd_frame_pkg::*;
    logic [7:0] rep [0:8];
    int n_rep = 0;
    initial
    begin
        rx = '0;
        rx_frame_start = 1'b0;
        tx_ready = 1'b0;
    end
    // A slow host drops tx_ready every other cycle, so held bytes get exercised
    always @(negedge ref_clk)
        tx_ready <= slow ? ~tx_ready : 1'b1;
    always @(posedge ref_clk)
        if (rx_frame_start && rx.valid)
            n_rep <= 0;
        else if (tx.valid && tx_ready && n_rep < 9)
        begin
            rep[n_rep] <= tx.data;
            n_rep <= n_rep + 1;
        end
    task automatic send(input logic [7:0] addr, input cmd_core_t c, input logic bad);
        logic [7:0] b [0:9];
        int i;
        b[0] = addr;
        {b[1], b[2], b[3], b[4], b[5], b[6], b[7]} = c;
        b[8] = bad ? 8'h5a : 8'h00;
        for (i = 0; i < 8; i++)
            b[8] = b[8] + b[i];
        for (i = int'(can_mode); i < 9 - int'(can_mode); i++)
        begin
            @(negedge ref_clk);
            rx.valid = 1'b1;
            rx.data = b[i];
            rx_frame_start = (i == int'(can_mode));
        end
        @(negedge ref_clk);
        rx.valid = 1'b0;
        rx.data = ~rx.data;
        rx_frame_start = 1'b0;
    endtask
endmodule

// ### sim/mcfi_assertions.sv
// Checker of reply framing and handshake order at the interpreter ports
`timescale 1ns/1ps
module mcfi_assertions
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic can_mode,
    input wire logic [7:0] reply_addr,
    input wire logic store_mode,
    input wire logic store_req,
    input wire logic exec_req,
    input wire logic exec_done,
    input wire logic store_done,
    input wire logic store_locked,
    input wire cmd_frame_pkg::byte_beat_t rx,
    input wire cmd_frame_pkg::byte_beat_t tx,
    input wire logic tx_ready,
    input wire logic tx_last
);
    import cmd_frame_pkg::*;
    // ----------------------------------------
    // Helper state: beats and sum of the reply so far
    // ----------------------------------------
    logic [3:0] cnt;
    logic [7:0] sum;
    logic armed;
    logic pend;
    wire take = tx.valid && tx_ready;
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            cnt <= 4'h0;
            sum <= 8'h00;
        end
        else if (take)
        begin
            cnt <= tx_last ? 4'h0 : cnt + 4'h1;
            sum <= tx_last ? 8'h00 : sum + tx.data;
        end
    // Armed stays set after a dropped frame, so this only catches fully unprompted replies
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            armed <= 1'b0;
            pend <= 1'b0;
        end
        else
        begin
            armed <= rx.valid || (armed && !(take && tx_last));
            pend <= exec_req || store_req || (pend && !(exec_done || store_done || store_locked));
        end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence last_beat;
        take && tx_last;
    endsequence
    sequence held_beat;
        tx.valid && !tx_ready;
    endsequence
    chk_reply_only: assert property (tx.valid |-> armed)
        else $error("reply byte with no command before it");
    chk_exec_first: assert property ((pend || exec_req || store_req) |-> !tx.valid)
        else $error("reply started before execution ended");
    chk_beat_hold: assert property (held_beat |=> tx.valid && $stable(tx.data))
        else $error("reply byte changed before it was taken");
    chk_reply_length: assert property (last_beat |-> cnt == (can_mode ? 4'h5 : 4'h8))
        else $error("reply length wrong");
    chk_reply_sum: assert property (last_beat and !can_mode |-> tx.data == sum)
        else $error("reply checksum wrong");
    chk_first_addr: assert property (take && cnt == 4'h0 && !can_mode |-> tx.data == reply_addr)
        else $error("reply does not open with reply address");
    chk_store_path: assert property (exec_req |-> !store_mode && !store_req)
        else $error("command executed while storing");
    chk_req_pulse: assert property (exec_req |=> !exec_req ##1 !exec_req)
        else $error("execute request longer than one pulse");
endmodule
bind motion_command_frame_interpreter mcfi_assertions u_chk
(
    .ref_clk(ref_clk), .rst(rst), .can_mode(can_mode), .reply_addr(reply_addr),
    .store_mode(store_mode), .store_req(store_req), .exec_req(exec_req),
    .exec_done(exec_done), .store_done(store_done), .store_locked(store_locked),
    .rx(rx), .tx(tx), .tx_ready(tx_ready), .tx_last(tx_last)
);

// ### sim/tb.sv
// Self-checking bench for the motion command frame interpreter
`timescale 1ns/1ps
module tb;
    import cmd_frame_pkg::*;
    localparam logic [7:0] MA = 8'h31;
    localparam logic [7:0] RA = 8'h07;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic can_mode = 1'b0;
    logic slow = 1'b0;
    logic store_mode = 1'b0;
    logic lock_on = 1'b0;
    logic store_done = 1'b0;
    logic store_locked = 1'b0;
    logic exec_done = 1'b0;
    logic [3:0] ed = 4'h0;
    logic [3:0] sd = 4'h0;
    exec_result_t res = '0;
    cmd_core_t store_cmd, exec_cmd;
    byte_beat_t rx, tx;
    logic rx_frame_start, store_req, exec_req, tx_ready, tx_last, tx_busy;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_exec = 0;
    always #25 ref_clk = ~ref_clk;
    // ----------------------------------------
    // Back end answers late so the reply has to wait for it
    // ----------------------------------------
    always @(negedge ref_clk)
    begin
        ed <= {ed[2:0], exec_req};
        sd <= {sd[2:0], store_req};
        exec_done <= ed[3];
        store_done <= sd[3] & ~lock_on;
        store_locked <= sd[3] & lock_on;
    end
    always @(posedge ref_clk)
        n_exec <= n_exec + int'(exec_req);
    motion_command_frame_interpreter DUT
    (
        .ref_clk(ref_clk), .rst(rst), .can_mode(can_mode), .module_addr(MA),
        .reply_addr(RA), .rx(rx), .rx_frame_start(rx_frame_start),
        .store_mode(store_mode), .store_ready(1'b1), .store_cmd(store_cmd),
        .store_req(store_req), .store_done(store_done), .store_locked(store_locked),
        .exec_cmd(exec_cmd), .exec_req(exec_req), .exec_done(exec_done),
        .exec_result(res), .tx(tx), .tx_ready(tx_ready), .tx_last(tx_last), .tx_busy(tx_busy)
    );
    host_model u_host
    (
        .ref_clk(ref_clk), .can_mode(can_mode), .slow(slow), .rx(rx),
        .rx_frame_start(rx_frame_start), .tx(tx), .tx_ready(tx_ready)
    );
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_core(input string what, input cmd_core_t exp, input cmd_core_t got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic frame(input logic [7:0] addr, input cmd_core_t c, input logic bad, input int n);
        int t;
        u_host.send(addr, c, bad);
        for (t = 0; t < 300 && u_host.n_rep < n; t++)
            @(negedge ref_clk);
        repeat (n == 0 ? 60 : 4) @(negedge ref_clk);
    endtask
    task automatic reply(input logic [7:0] op, input logic [7:0] st, input logic [31:0] v,
                         input logic with_v);
        logic [7:0] e [0:8];
        int k;
        int i;
        k = can_mode ? 2 : 0;
        {e[0], e[1], e[2], e[3]} = {RA, MA, st, op};
        {e[4], e[5], e[6], e[7]} = v;
        e[8] = 8'h00;
        for (i = 0; i < 8; i++)
            e[8] = e[8] + e[i];
        check8("reply count", can_mode ? 8'h06 : 8'h09, 8'(u_host.n_rep));
        check8("tx busy", 8'h00, {7'h00, tx_busy});
        for (i = k; i < 9 - k / 2; i++)
            if (with_v || i < 4)
                check8("reply byte", e[i], u_host.rep[i - k]);
    endtask
    task automatic sc_exec;
        cmd_core_t c;
        c = {8'h04, 8'h01, 8'h00, 32'h8001_7f02};
        slow = 1'b1;
        res = {ST_OK, 32'h89ab_cdef};
        frame(MA, c, 1'b0, 9);
        check_core("exec cmd", c, exec_cmd);
        reply(8'h04, ST_OK, 32'h89ab_cdef, 1'b1);
        slow = 1'b0;
    endtask
    task automatic sc_bad_sum;
        int t;
        t = n_exec;
        frame(MA, {8'h05, 8'h02, 8'h00, 32'h0000_0001}, 1'b1, 9);
        check8("exec count", 8'(t), 8'(n_exec));
        reply(8'h05, ST_BAD_SUM, 32'h0, 1'b0);
    endtask
    task automatic sc_errors;
        logic [7:0] st [4] = '{ST_BAD_OPCODE, ST_BAD_TYPE, ST_BAD_VALUE, ST_UNAVAILABLE};
        int i;
        for (i = 0; i < 4; i++)
        begin
            res = {st[i], 32'hffff_0000};
            frame(MA, {st[i] + 8'hf0, 8'h00, 8'h00, 32'h0}, 1'b0, 9);
            reply(st[i] + 8'hf0, st[i], 32'hffff_0000, 1'b1);
        end
    endtask
    task automatic sc_store;
        cmd_core_t c;
        c = {8'h0b, 8'h03, 8'h02, 32'h00c0_ffee};
        store_mode = 1'b1;
        frame(MA, c, 1'b0, 9);
        check_core("store cmd", c, store_cmd);
        reply(8'h0b, ST_STORED, 32'h0, 1'b0);
        lock_on = 1'b1;
        frame(MA, c, 1'b0, 9);
        reply(8'h0b, ST_LOCKED, 32'h0, 1'b0);
        lock_on = 1'b0;
        store_mode = 1'b0;
    endtask
    task automatic sc_foreign;
        frame(MA + 8'h01, {8'h01, 8'h00, 8'h00, 32'h5}, 1'b0, 0);
        check8("reply count", 8'h00, 8'(u_host.n_rep));
    endtask
    task automatic sc_can;
        cmd_core_t c;
        c = {8'h06, 8'h04, 8'h01, 32'hfedc_0011};
        can_mode = 1'b1;
        res = {ST_OK, 32'h0102_0304};
        frame(8'h00, c, 1'b0, 6);
        check_core("exec cmd", c, exec_cmd);
        reply(8'h06, ST_OK, 32'h0102_0304, 1'b1);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        sc_exec();
        sc_bad_sum();
        sc_errors();
        sc_store();
        sc_foreign();
        sc_can();
        print_verdict();
    end
    // Whole run needs a few hundred cycles; twenty thousand means a hang
    initial
    begin
        #1000000;
        n_mismatch++;
        print_verdict();
    end
endmodule
